// File: design/pwm_params.svh
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// ==================================================
// register offsets and reset values
`define PWM_OFS_CTRL    12'h000
`define PWM_OFS_PER0    12'h004
`define PWM_OFS_PER1    12'h008
`define PWM_CTRL_RST    32'h0000_0000
`define PWM_PER_RST     32'h0000_0000

// ==================================================
// control fields, channel 1 sits one stride above channel 0, except its busy flag, one bit above
`define PWM_F_EN        4
`define PWM_F_ACT       5
`define PWM_F_GATE      6
`define PWM_F_MODE      7
`define PWM_F_GO        8
`define PWM_F_BYP       9
`define PWM_CH_STRIDE   15
`define PWM_F_BUSY      28
`define PWM_CTRL_WMASK  32'h01ff_83ff
`define PWM_GO_MASK     32'h0080_0100

// ==================================================
// prescaler codes and ratios
`define PWM_PS_120      4'h0
`define PWM_PS_180      4'h1
`define PWM_PS_240      4'h2
`define PWM_PS_360      4'h3
`define PWM_PS_480      4'h4
`define PWM_PS_12K      4'h8
`define PWM_PS_24K      4'h9
`define PWM_PS_36K      4'ha
`define PWM_PS_48K      4'hb
`define PWM_PS_72K      4'hc
`define PWM_PS_ONE      4'hf
`define PWM_DIV_120     17'h0_0078
`define PWM_DIV_180     17'h0_00b4
`define PWM_DIV_240     17'h0_00f0
`define PWM_DIV_360     17'h0_0168
`define PWM_DIV_480     17'h0_01e0
`define PWM_DIV_12K     17'h0_2ee0
`define PWM_DIV_24K     17'h0_5dc0
`define PWM_DIV_36K     17'h0_8ca0
`define PWM_DIV_48K     17'h0_bb80
`define PWM_DIV_72K     17'h1_1940
`define PWM_DIV_ONE     17'h0_0001

`endif

// File: design/pwm_pkg.sv
package pwm_pkg;

  // ==================================================
  // channel sequencing
  typedef enum logic [2:0]
  {
    PWM_IDLE  = 3'b001,
    PWM_CYCLE = 3'b010,
    PWM_PULSE = 3'b100
  } pwm_chst_type;

  // ==================================================
  // whole module state
  typedef struct packed
  {
    logic [31:0]                  ctrl;
    logic [1:0][31:0]             per_new;
    logic [1:0][31:0]             per_cur;
    logic [1:0]                   busy;
    logic [1:0][16:0]             pdiv;
    logic [1:0][15:0]             cnt;
    pwm_chst_type [1:0]           st;
    logic [1:0]                   level;
    logic                         dsel;
    logic                         dwr;
    logic [11:0]                  daddr;
    logic [31:0]                  rdata;
  } pwm_state_type;

endpackage

// File: design/pwm_top.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_params.svh"

// Summary of operation
// - per channel 16-bit counter restarts at period
// - period start drives active level, counter zero
// - mode bit picks cycle or single pulse
// - pins inverted pair; disabled still drives both
// - four-bit prescaler selects documented divide ratios
// - gate bit blocks or passes divided clock
// - active-level bit picks low or high
// - enable bit disables or enables channel
// - bypass bit routes reference oscillator to output
// - start bit emits one pulse, then self-clears
// - busy flag shows a period write not yet taken up
// - upper field N gives N+1 cycles
// - lower field N gives N active cycles
// - counter divides prescaled clock up to 65536
module pwm_top
  import pwm_pkg::*;
#(
  parameter logic [16:0] DIV_12K = `PWM_DIV_12K,
  parameter logic [16:0] DIV_24K = `PWM_DIV_24K,
  parameter logic [16:0] DIV_36K = `PWM_DIV_36K,
  parameter logic [16:0] DIV_48K = `PWM_DIV_48K,
  parameter logic [16:0] DIV_72K = `PWM_DIV_72K
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        reference_oscillator,
  output logic [1:0]       modulated_output,
  output logic [1:0]       modulated_output_n
);

  // ==================================================
  // elaboration checks
  if (DIV_12K == '0 || DIV_24K == '0 || DIV_36K == '0 ||
      DIV_48K == '0 || DIV_72K == '0)
  begin : g_bad_div
    $error("prescaler ratios must be nonzero");
  end

  // ==================================================
  // helpers
  function automatic logic [16:0] pwm_ratio(input logic [3:0] code);
    logic [16:0] v;
    v = '0;
    case (code)
      `PWM_PS_120: v = `PWM_DIV_120;
      `PWM_PS_180: v = `PWM_DIV_180;
      `PWM_PS_240: v = `PWM_DIV_240;
      `PWM_PS_360: v = `PWM_DIV_360;
      `PWM_PS_480: v = `PWM_DIV_480;
      `PWM_PS_12K: v = DIV_12K;
      `PWM_PS_24K: v = DIV_24K;
      `PWM_PS_36K: v = DIV_36K;
      `PWM_PS_48K: v = DIV_48K;
      `PWM_PS_72K: v = DIV_72K;
      `PWM_PS_ONE: v = `PWM_DIV_ONE;
      // undefined codes stop the divider rather than guess a ratio
      default:     v = '0;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] pwm_read(input pwm_state_type s,
                                           input logic [11:0]   a);
    logic [31:0] v;
    v = '0;
    if (a == `PWM_OFS_CTRL)
    begin
      v = s.ctrl;
      v[`PWM_F_BUSY]   = s.busy[0];
      v[`PWM_F_BUSY+1] = s.busy[1];
    end
    else if (a == `PWM_OFS_PER0)
      v = s.per_new[0];
    else if (a == `PWM_OFS_PER1)
      v = s.per_new[1];
    return v;
  endfunction

  // ==================================================
  // state
  pwm_state_type r_ff;
  pwm_state_type nxt_r;
  logic [1:0]    tick_c;
  logic [1:0]    bnd_c;
  logic          accept;
  logic          wr_ctrl;
  logic          wr_per0;
  logic          rd_ctrl;

  assign accept  = hsel && hready && htrans[1];
  assign wr_ctrl = r_ff.dsel && r_ff.dwr && r_ff.daddr == `PWM_OFS_CTRL;
  assign wr_per0 = r_ff.dsel && r_ff.dwr && r_ff.daddr == `PWM_OFS_PER0;
  // a control read in its address phase, watched by the busy check
  assign rd_ctrl = accept && !hwrite && haddr[11:0] == `PWM_OFS_CTRL;

  always_comb
  begin
    int          b;
    logic [16:0] ratio;
    logic        en;
    logic        act;
    logic        gate;
    logic        mode;
    logic        go;
    logic        byp;
    logic        lvl;
    logic [15:0] per_n;
    logic [15:0] act_n;
    b      = 0;
    ratio  = '0;
    en     = 1'b0;
    act    = 1'b0;
    gate   = 1'b0;
    mode   = 1'b0;
    go     = 1'b0;
    byp    = 1'b0;
    lvl    = 1'b0;
    per_n  = '0;
    act_n  = '0;
    nxt_r  = r_ff;
    tick_c = '0;
    bnd_c  = '0;
    for (int c = 0; c < 2; c++)
    begin
      b     = c * `PWM_CH_STRIDE;
      en    = r_ff.ctrl[b+`PWM_F_EN];
      act   = r_ff.ctrl[b+`PWM_F_ACT];
      gate  = r_ff.ctrl[b+`PWM_F_GATE];
      mode  = r_ff.ctrl[b+`PWM_F_MODE];
      go    = r_ff.ctrl[b+`PWM_F_GO];
      byp   = r_ff.ctrl[b+`PWM_F_BYP];
      ratio = pwm_ratio(r_ff.ctrl[b+:4]);
      per_n = r_ff.per_cur[c][31:16];
      act_n = r_ff.per_cur[c][15:0];
      // divider restarts whenever the gate closes, so a reopen is clean
      if (gate && ratio != '0)
      begin
        if (r_ff.pdiv[c] >= ratio - 17'h0_0001)
        begin
          nxt_r.pdiv[c] = '0;
          tick_c[c]     = 1'b1;
        end
        else
          nxt_r.pdiv[c] = r_ff.pdiv[c] + 17'h0_0001;
      end
      else
        nxt_r.pdiv[c] = '0;
      bnd_c[c] = tick_c[c] && r_ff.cnt[c] == per_n;
      if (r_ff.busy[c] && (r_ff.st[c] == PWM_IDLE || bnd_c[c]))
      begin
        nxt_r.per_cur[c] = r_ff.per_new[c];
        nxt_r.busy[c]    = 1'b0;
      end
      case (r_ff.st[c])
        PWM_IDLE:
        begin
          nxt_r.cnt[c] = '0;
          if (en && !mode)
            nxt_r.st[c] = PWM_CYCLE;
          else if (en && go)
            nxt_r.st[c] = PWM_PULSE;
        end
        PWM_CYCLE:
        begin
          if (!en || mode)
          begin
            nxt_r.st[c]  = PWM_IDLE;
            nxt_r.cnt[c] = '0;
          end
          else if (bnd_c[c])
            nxt_r.cnt[c] = '0;
          else if (tick_c[c])
            nxt_r.cnt[c] = r_ff.cnt[c] + 16'h0001;
        end
        PWM_PULSE:
        begin
          if (!en || r_ff.cnt[c] >= act_n)
          begin
            nxt_r.st[c]            = PWM_IDLE;
            nxt_r.cnt[c]           = '0;
            nxt_r.ctrl[b+`PWM_F_GO] = 1'b0;
          end
          else if (tick_c[c])
            nxt_r.cnt[c] = r_ff.cnt[c] + 16'h0001;
        end
        default:
          nxt_r.st[c] = PWM_IDLE;
      endcase
      // idle, disabled and pulse rest all show the inactive level
      lvl = !act;
      if (nxt_r.st[c] != PWM_IDLE && nxt_r.cnt[c] < nxt_r.per_cur[c][15:0])
        lvl = act;
      nxt_r.level[c] = byp ? reference_oscillator : lvl;
    end
    // bus writes land after the channel logic, so a write beats a clear
    if (r_ff.dsel && r_ff.dwr)
    begin
      if (r_ff.daddr == `PWM_OFS_CTRL)
        nxt_r.ctrl = (hwdata & `PWM_CTRL_WMASK) | (nxt_r.ctrl & `PWM_GO_MASK);
      else if (r_ff.daddr == `PWM_OFS_PER0)
      begin
        nxt_r.per_new[0] = hwdata;
        nxt_r.busy[0]    = 1'b1;
      end
      else if (r_ff.daddr == `PWM_OFS_PER1)
      begin
        nxt_r.per_new[1] = hwdata;
        nxt_r.busy[1]    = 1'b1;
      end
    end
    nxt_r.dsel  = accept;
    nxt_r.dwr   = hwrite;
    nxt_r.daddr = haddr[11:0];
    // read sees a write still in its data phase
    if (accept && !hwrite)
      nxt_r.rdata = pwm_read(nxt_r, haddr[11:0]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_ff         <= '0;
      r_ff.ctrl    <= `PWM_CTRL_RST;
      r_ff.per_new <= {2{`PWM_PER_RST}};
      r_ff.per_cur <= {2{`PWM_PER_RST}};
      r_ff.st[0]   <= PWM_IDLE;
      r_ff.st[1]   <= PWM_IDLE;
    end
    else
      r_ff <= nxt_r;
  end

  // ==================================================
  // outputs
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = r_ff.rdata;
  assign modulated_output   = r_ff.level;
  assign modulated_output_n = ~r_ff.level;

  // ==================================================
  // assertions, channel 0
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s0_pulse_done;
    r_ff.st[0] == PWM_PULSE ##1 r_ff.st[0] == PWM_IDLE;
  endsequence

  chk_counter_wrap: assert property (
    bnd_c[0] && r_ff.st[0] == PWM_CYCLE && r_ff.ctrl[`PWM_F_EN] &&
    !r_ff.ctrl[`PWM_F_MODE] |=> r_ff.cnt[0] == '0)
    else $error("counter did not restart at period");

  chk_count_step: assert property (
    r_ff.st[0] == PWM_CYCLE && tick_c[0] && !bnd_c[0] &&
    r_ff.ctrl[`PWM_F_EN] && !r_ff.ctrl[`PWM_F_MODE]
    |=> r_ff.cnt[0] == $past(r_ff.cnt[0]) + 16'h0001)
    else $error("counter did not step on tick");

  chk_period_start: assert property (
    bnd_c[0] && r_ff.st[0] == PWM_CYCLE && r_ff.ctrl[`PWM_F_EN] &&
    !r_ff.ctrl[`PWM_F_MODE] && !r_ff.ctrl[`PWM_F_BYP] &&
    nxt_r.per_cur[0][15:0] != '0
    |=> modulated_output[0] == $past(r_ff.ctrl[`PWM_F_ACT]))
    else $error("period start not at active level");

  chk_idle_level: assert property (
    (!r_ff.ctrl[`PWM_F_EN] && !r_ff.ctrl[`PWM_F_BYP])[*2] ##0
    $stable(r_ff.ctrl[`PWM_F_ACT])
    |-> modulated_output[0] == !r_ff.ctrl[`PWM_F_ACT] &&
        modulated_output_n[0] == r_ff.ctrl[`PWM_F_ACT])
    else $error("disabled channel not at inactive level");

  chk_pulse_rest: assert property (
    (r_ff.ctrl[`PWM_F_MODE] && !r_ff.ctrl[`PWM_F_BYP] &&
     !r_ff.ctrl[`PWM_F_GO])[*2] ##0 $stable(r_ff.ctrl[`PWM_F_ACT])
    |-> modulated_output[0] == !r_ff.ctrl[`PWM_F_ACT])
    else $error("pulse mode not resting inactive");

  chk_pulse_active: assert property (
    r_ff.st[0] == PWM_PULSE && r_ff.cnt[0] < r_ff.per_cur[0][15:0] &&
    !$past(r_ff.ctrl[`PWM_F_BYP]) && $stable(r_ff.ctrl[`PWM_F_ACT])
    |-> modulated_output[0] == r_ff.ctrl[`PWM_F_ACT])
    else $error("pulse not at active level");

  chk_go_clear: assert property (
    s0_pulse_done ##0 !$past(wr_ctrl) |-> !r_ff.ctrl[`PWM_F_GO])
    else $error("start bit not cleared after pulse");

  chk_mode_select: assert property (
    r_ff.st[0] == PWM_IDLE && r_ff.ctrl[`PWM_F_EN] &&
    !r_ff.ctrl[`PWM_F_MODE] |=> r_ff.st[0] == PWM_CYCLE)
    else $error("cycle mode not entered");

  chk_enable_off: assert property (
    !r_ff.ctrl[`PWM_F_EN] |=> r_ff.st[0] == PWM_IDLE)
    else $error("disabled channel still running");

  chk_gate_block: assert property (
    !r_ff.ctrl[`PWM_F_GATE] |-> !tick_c[0] ##1 r_ff.pdiv[0] == '0)
    else $error("closed gate let a tick pass");

  chk_div_one: assert property (
    (r_ff.ctrl[`PWM_F_GATE] && r_ff.ctrl[3:0] == `PWM_PS_ONE)[*2]
    |-> tick_c[0])
    else $error("divide by one missed a tick");

  chk_bypass_path: assert property (
    r_ff.ctrl[`PWM_F_BYP] |=> modulated_output[0] == $past(reference_oscillator))
    else $error("bypass not carrying oscillator");

  chk_busy_set: assert property (
    wr_per0 |=> r_ff.busy[0] ##1
    (!$past(rd_ctrl) || r_ff.rdata[`PWM_F_BUSY] == r_ff.busy[0]))
    else $error("busy not raised by period write");

  chk_busy_clear: assert property (
    r_ff.busy[0] && r_ff.st[0] == PWM_IDLE && !wr_per0
    |=> !r_ff.busy[0] && r_ff.per_cur[0] == $past(r_ff.per_new[0]))
    else $error("period value not transferred");

endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwm_params.svh"

// ==================================================
// one compare, counted; mismatch printed at once
`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              reference_oscillator;
  wire logic         hready;
  wire logic         hresp;
  wire logic [31:0]  hrdata;
  wire logic [1:0]   modulated_output;
  wire logic [1:0]   modulated_output_n;
  int                bad_count;
  int                n_tests;
  logic [31:0]       q;
  logic [31:0]       d;
  int                cnt;
  int                np;
  int                na;
  int                i;
  logic [3:0]        codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb,
                                    4'hc, 4'hf};
  // ratios follow the shortened divider parameters handed to the design below
  int                ratio [11] = '{120, 180, 240, 360, 480, 12, 24, 36, 48, 72, 1};

  pwm_top #(.DIV_12K(17'h0_000c), .DIV_24K(17'h0_0018), .DIV_36K(17'h0_0024),
            .DIV_48K(17'h0_0030), .DIV_72K(17'h0_0048)) dut
  (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hready),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .reference_oscillator (reference_oscillator),
    .modulated_output     (modulated_output),
    .modulated_output_n   (modulated_output_n)
  );

  initial
  begin
    hclk = 1'b0;
  end

  always #50 hclk = ~hclk;

  // ==================================================
  // bus master: entered just after a rising edge, leaves on one
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("response", 1'b0, hresp)
  endtask

  // counts cycles at a level; pins must stay a mutually inverted pair
  task automatic meas(input int ch, input logic lvl, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge hclk);
      if (modulated_output[ch] === lvl) c++;
      `CHK("pin pair", ~modulated_output[ch], modulated_output_n[ch])
    end
    @(posedge hclk);
  endtask

  task conclude;
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==================================================
  // watchdog, well beyond the roughly 10k cycles the tests need
  initial
  begin
    #5000000;
    bad_count++;
    conclude();
  end

  // ==================================================
  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    reference_oscillator = 1'b0;
    bad_count = 0;
    n_tests = 0;
    d = $urandom(32'he954);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `PWM_OFS_CTRL, 32'h0000_0000, q);
    `CHK("control reset", 32'h0000_0000, q)
    // active level low after reset, so idle pins rest high
    `CHK("pins at reset", 4'b0011, {modulated_output_n, modulated_output})
    // unmapped place and read-only busy bits must not take writes
    bus(1'b1, 12'h00c, $urandom, q);
    bus(1'b0, 12'h00c, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    repeat (4)
    begin
      d = $urandom & `PWM_CTRL_WMASK & ~`PWM_GO_MASK & ~32'h0008_0010;
      bus(1'b1, `PWM_OFS_CTRL, d | 32'h3000_0000, q);
      bus(1'b0, `PWM_OFS_CTRL, 32'h0000_0000, q);
      `CHK("control fields", d, q)
      d = $urandom;
      bus(1'b1, `PWM_OFS_PER1, d, q);
      bus(1'b0, `PWM_OFS_PER1, 32'h0000_0000, q);
      `CHK("period store", d, q)
    end
    // cycle mode on channel 0, undivided, random period and duty
    for (i = 0; i < 4; i++)
    begin
      np = 1 + $urandom_range(6);
      na = $urandom_range(np + 1);
      bus(1'b1, `PWM_OFS_CTRL, 32'h0000_0000, q);
      bus(1'b1, `PWM_OFS_PER0, {np[15:0], na[15:0]}, q);
      bus(1'b1, `PWM_OFS_CTRL, 32'h0000_005f | {26'h0, i[0], 5'h0}, q);
      meas(0, i[0], 3 * (np + 1), cnt);
      meas(0, i[0], 8 * (np + 1), cnt);
      `CHK("duty ch0", 8 * na, cnt)
    end
    // every defined divider code on channel 1; divider set before the gate opens
    for (i = 0; i < 11; i++)
    begin
      bus(1'b1, `PWM_OFS_CTRL, 32'h0000_0000, q);
      bus(1'b1, `PWM_OFS_PER1, 32'h0001_0001, q);
      bus(1'b1, `PWM_OFS_CTRL, {13'h0000, codes[i], 15'h0000}, q);
      bus(1'b1, `PWM_OFS_CTRL, {10'h000, 3'b111, codes[i], 15'h0000}, q);
      meas(1, 1'b1, 2 * ratio[i] + 4, cnt);
      meas(1, 1'b1, 4 * ratio[i], cnt);
      `CHK("divider ch1", 2 * ratio[i], cnt)
    end
    // live period rewrite waits for the boundary, busy meanwhile
    bus(1'b1, `PWM_OFS_CTRL, 32'h0000_0000, q);
    bus(1'b1, `PWM_OFS_PER0, 32'h0003_0001, q);
    bus(1'b1, `PWM_OFS_CTRL, 32'h0000_005c, q);
    bus(1'b1, `PWM_OFS_PER0, 32'h0002_0001, q);
    bus(1'b0, `PWM_OFS_CTRL, 32'h0000_0000, q);
    `CHK("busy set", 1'b1, q[28])
    for (i = 0; i < 200 && q[28] !== 1'b0; i++)
      bus(1'b0, `PWM_OFS_CTRL, 32'h0000_0000, q);
    `CHK("busy clear", 1'b0, q[28])
    bus(1'b0, `PWM_OFS_PER0, 32'h0000_0000, q);
    `CHK("period kept", 32'h0002_0001, q)
    // single pulse of five ticks, then the start bit clears itself
    // active level set first: a level change reaches the pin a clock late
    bus(1'b1, `PWM_OFS_CTRL, 32'h0000_0020, q);
    bus(1'b1, `PWM_OFS_PER0, 32'h0009_0005, q);
    bus(1'b1, `PWM_OFS_CTRL, 32'h0000_01ff, q);
    meas(0, 1'b1, 40, cnt);
    `CHK("pulse width", 5, cnt)
    bus(1'b0, `PWM_OFS_CTRL, 32'h0000_0000, q);
    `CHK("start cleared", 32'h0000_00ff, q)
    // oscillator passthrough, even with the channel disabled
    bus(1'b1, `PWM_OFS_CTRL, 32'h0000_0200, q);
    repeat (16)
    begin
      d = $urandom;
      reference_oscillator <= d[0];
      @(posedge hclk);
      @(negedge hclk);
      `CHK("bypass", d[0], modulated_output[0])
      @(posedge hclk);
    end
    conclude();
  end
endmodule

`default_nettype wire
